/* hdl/rkt_top.sv */
// Keypad scanner and biphase remote code transmitter with Wishbone control
//
// Local design decisions: the register addresses and the Wishbone register port.
`default_nettype none

module rkt_top #(
  parameter int OSC_DIV = rkt_pkg::OSC_DIV_CYC            // Core cycles per oscillator tick
) (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [rkt_pkg::REG_AW-1:0]  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output var  logic [31:0]                 wb_dat_o,
  output var  logic                        wb_ack_o,
  input  wire logic [7:0]                  command_sense_inputs,
  input  wire logic [3:0]                  system_sense_inputs,
  input  wire logic                        single_system_select,
  input  wire logic                        test_fast_scan,
  input  wire logic                        test_fast_latch_read,
  input  wire logic                        resonator_pin,
  output var  logic [7:0]                  scan_strobe_out,
  output var  logic [7:0]                  scan_strobe_oe_n,
  output var  logic                        command_pullup_on,
  output var  logic                        system_pullup_on,
  output var  logic                        data_out,
  output var  logic                        data_oe_n,
  output var  logic                        carrier_modulated_output,
  output var  logic                        carrier_modulated_oe_n
);
  import rkt_pkg::*;

  // Index of the lowest active bit, shared by both matrices
  function automatic logic [2:0] rkt_index(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
        idx = 3'(i);
    end
    return idx;
  endfunction

  // Pin synchroniser, two stages
  logic [15:0] pin_raw;                      // All asynchronous pins
  logic [15:0] pin_meta_r;                   // First stage, read by second only
  logic [15:0] pin_sync_r;                   // Safe to use
  assign pin_raw = {resonator_pin, test_fast_latch_read, test_fast_scan,
                    single_system_select, system_sense_inputs, command_sense_inputs};

  always_ff @(posedge core_clk)
  begin
    pin_meta_r <= pin_raw;
    pin_sync_r <= pin_meta_r;
  end

  wire [7:0] cmd_s    = pin_sync_r[7:0];     // Command sense, low = key
  wire [3:0] sys_s    = pin_sync_r[11:8];    // System sense, low = key
  wire       ssm_s    = pin_sync_r[12];      // Single-system mode
  wire       fscan_s  = pin_sync_r[13];      // Fast scan test
  wire       fread_s  = pin_sync_r[14];      // Fast read-out test
  wire       osc_s    = pin_sync_r[15];      // Resonator pin level

  // Registers and state
  rkt_state_t  st_r;                         // Sequencer state
  rkt_state_t  st_nxt;
  logic [15:0] div_r;                        // Oscillator divider
  logic        osc_tick_r;                   // One-cycle oscillator tick
  logic [9:0]  tick_r;                       // Osc ticks within a unit
  logic [6:0]  unit_r;                       // Bits, steps or half-bits
  logic [3:0]  car_r;                        // Carrier phase
  logic [5:0]  cmd_lat_r;                    // Command latch
  logic [4:0]  sys_lat_r;                    // System latch
  logic        cmd_found_r;                  // Command seen this scan
  logic        sys_found_r;                  // System seen this scan
  logic        seen_r;                       // Key seen in pass one
  logic [2:0]  key_step_r;                   // Strobe where it was seen
  logic        all_ones_r;                   // Send all-ones command
  logic        toggle_r;                     // Control bit of the frame
  logic        sent_r;                       // Frame completed since last flip
  logic        ctrl_en_r;                    // Software enable
  logic        ack_r;
  logic [31:0] rdat_r;
  logic [7:0]  strobe_oe_n_r;
  logic        cmd_pu_r;
  logic        sys_pu_r;
  logic        dout_r;
  logic        doe_n_r;
  logic        mout_r;

  // Key detection in the idle, debounce and gap states
  wire [7:0]  cmd_low   = ~cmd_s;
  wire [3:0]  sys_low   = ssm_s ? 4'h0 : ~sys_s;
  wire [11:0] key_lows  = {sys_low, cmd_low};
  wire        key_any   = |key_lows;
  wire        key_legal = $onehot(key_lows);

  // Unit timing: step, half-bit or bit depending on state
  wire [9:0] tick_lim = (st_r == ST_SCAN) ? (fscan_s ? STEP_FAST : STEP_TICKS) :
                        (st_r == ST_TX)   ? (fread_s ? HALF_FAST : HALF_TICKS) :
                        BIT_TICKS;
  wire       unit_done = osc_tick_r && (tick_r == tick_lim - 10'h1);
  wire       init_req  = fscan_s & fread_s & osc_s;
  wire       clr       = reset | init_req;

  // Scan decode at the end of each strobe step
  wire [2:0] step      = unit_r[2:0];
  wire       pass1     = unit_r[3];
  // Only a single low line counts
  wire       cmd_hit   = cmd_pu_r && $onehot(cmd_low);
  wire       sys_hit   = sys_pu_r && $onehot(~sys_s);
  // Command number is sense line then strobe
  wire [5:0] cmd_code  = {rkt_index(cmd_low), step};
  // System number is sense line then strobe
  wire [2:0] sys_line  = rkt_index({4'h0, ~sys_s}); // Only two low bits can be set
  wire [4:0] sys_code  = {sys_line[1:0], step};
  wire       cmd_ok    = cmd_found_r | cmd_hit;
  wire       sys_ok    = sys_found_r | sys_hit;
  wire       step_end  = (st_r == ST_SCAN) && unit_done;
  // Key vanished where it was seen
  wire       lost_key  = step_end && pass1 && !ssm_s && seen_r &&
                         (step == key_step_r) && !(cmd_hit | sys_hit);
  wire       no_system = step_end && ssm_s && (unit_r == PASS0_LAST) && !sys_ok;
  wire       scan_fin  = step_end && (unit_r == SCAN_LAST);
  wire       scan_good = ssm_s ? (cmd_ok && sys_ok) : (cmd_ok || sys_ok);

  // Frame word and biphase level
  wire [5:0]  cmd_word  = all_ones_r ? CMD_ALL_ONES : cmd_lat_r;
  wire [13:0] frame_w   = {START_BITS, toggle_r, sys_lat_r, cmd_word};
  wire [3:0]  bit_idx   = 4'(FRAME_BITS - 1) - unit_r[4:1];
  // One is low then high, zero the reverse
  wire        tx_level  = frame_w[bit_idx] ? unit_r[0] : ~unit_r[0];
  wire        car_on    = car_r < CAR_ON_CNT;

  // Wishbone decode
  wire wb_req  = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wb_wr   = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_CTRL);
  wire [31:0] status_w = (32'(st_r) << STAT_STATE_LSB) | (32'(toggle_r) << STAT_TOGGLE_BIT) |
                         (32'(sys_lat_r) << STAT_SYS_LSB) | (32'(cmd_lat_r) << STAT_CMD_LSB) |
                         (32'(sent_r) << STAT_SENT_BIT);
  wire [31:0] rd_mux   = (wb_adr_i == REG_CTRL)   ? 32'(ctrl_en_r) :
                         (wb_adr_i == REG_STATUS) ? status_w : 32'h0;

  // Next state
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE:
        if (ctrl_en_r && key_legal)
          st_nxt = ST_DEBOUNCE;
      ST_DEBOUNCE:
        if (!key_legal)
          st_nxt = ST_IDLE;
        else if (unit_done && unit_r == DEB_LAST)
          st_nxt = ST_SCAN;
      ST_SCAN:
        // Lost key or missing system resets
        if (lost_key || no_system)
          st_nxt = ST_IDLE;
        else if (scan_fin)
          st_nxt = scan_good ? ST_TX : ST_IDLE;
      ST_TX:
        if (unit_done && unit_r == TX_LAST)
          st_nxt = ST_GAP;
      ST_GAP:
        if (!key_any)
          st_nxt = ST_IDLE;
        // Rescan so frames repeat every 64 bits
        else if (unit_done && unit_r == GAP_LAST)
          st_nxt = ST_SCAN;
      default:
        st_nxt = ST_IDLE;
    endcase
    if (!ctrl_en_r)
      st_nxt = ST_IDLE;
  end

  // Oscillator divider and carrier phase
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      div_r      <= 16'h0;
      osc_tick_r <= 1'b0;
      car_r      <= 4'h0;
    end
    else
    begin
      osc_tick_r <= (div_r == 16'(OSC_DIV - 1));
      div_r      <= (div_r == 16'(OSC_DIV - 1)) ? 16'h0 : div_r + 16'h1;
      if (osc_tick_r)
        car_r <= (car_r == CAR_LAST) ? 4'h0 : car_r + 4'h1;
    end
  end

  // Sequencer and unit counters
  always_ff @(posedge core_clk)
  begin
    if (clr)
    begin
      st_r   <= ST_IDLE;
      tick_r <= 10'h0;
      unit_r <= 7'h0;
    end
    else
    begin
      st_r <= st_nxt;
      // Counters restart on every state change
      if (st_nxt != st_r)
      begin
        tick_r <= 10'h0;
        unit_r <= 7'h0;
      end
      else if (unit_done)
      begin
        tick_r <= 10'h0;
        unit_r <= unit_r + 7'h1;
      end
      else if (osc_tick_r)
        tick_r <= tick_r + 10'h1;
    end
  end

  // Code latches: cleared only by reset, never by test init
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cmd_lat_r <= 6'h0;
      sys_lat_r <= 5'h0;
    end
    else if (step_end)
    begin
      if (cmd_hit)
        cmd_lat_r <= cmd_code;
      if (sys_hit)
        sys_lat_r <= sys_code;
    end
  end

  // Scan bookkeeping and frame selection
  always_ff @(posedge core_clk)
  begin
    if (clr)
    begin
      cmd_found_r <= 1'b0;
      sys_found_r <= 1'b0;
      seen_r      <= 1'b0;
      key_step_r  <= 3'h0;
      all_ones_r  <= 1'b0;
    end
    else if (st_r != ST_SCAN && st_nxt == ST_SCAN)
    begin
      cmd_found_r <= 1'b0;
      sys_found_r <= ssm_s ? 1'b0 : sys_found_r & 1'b0;
      seen_r      <= 1'b0;
    end
    else if (step_end)
    begin
      cmd_found_r <= cmd_ok;
      sys_found_r <= sys_ok;
      if ((cmd_hit | sys_hit) && !pass1)
      begin
        seen_r     <= 1'b1;
        key_step_r <= step;
      end
      if (unit_r == SCAN_LAST)
        all_ones_r <= !ssm_s && !cmd_ok;
    end
  end

  // Toggle control bit
  always_ff @(posedge core_clk)
  begin
    if (clr)
    begin
      toggle_r <= 1'b0;
      sent_r   <= 1'b0;
    end
    else if (st_r == ST_TX && st_nxt == ST_GAP)
      sent_r <= 1'b1;
    // Flip on return to idle after release
    else if (st_r != ST_IDLE && st_nxt == ST_IDLE && sent_r)
    begin
      toggle_r <= ~toggle_r;
      sent_r   <= 1'b0;
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge core_clk)
  begin
    if (clr)
    begin
      strobe_oe_n_r <= 8'h00;
      cmd_pu_r      <= 1'b1;
      sys_pu_r      <= 1'b1;
      dout_r        <= 1'b0;
      doe_n_r       <= 1'b1;
      mout_r        <= 1'b0;
    end
    else
    begin
      // One strobe conducts per scan step
      strobe_oe_n_r <= (st_r == ST_SCAN) ? ~(8'h01 << step) : 8'h00;
      // Combined mode keeps both pull-ups on
      // Single mode pass one: system lines only
      // Single mode pass two: command lines only
      cmd_pu_r <= !(ssm_s && st_r == ST_SCAN && !pass1);
      sys_pu_r <= !ssm_s || (st_r == ST_SCAN && !pass1);
      dout_r   <= (st_r == ST_TX) && tx_level;
      doe_n_r  <= (st_r != ST_TX);
      mout_r   <= (st_r == ST_TX) && tx_level && car_on;
    end
  end

  // Wishbone slave: one wait state, ack for any address
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ack_r     <= 1'b0;
      rdat_r    <= 32'h0;
      ctrl_en_r <= CTRL_EN_RST;
    end
    else
    begin
      ack_r  <= wb_req;
      rdat_r <= wb_req ? rd_mux : 32'h0;
      if (wb_wr)
        ctrl_en_r <= wb_dat_i[CTRL_EN_BIT];
    end
  end

  assign wb_ack_o                 = ack_r;
  assign wb_dat_o                 = rdat_r;
  assign scan_strobe_out          = 8'h00;
  assign scan_strobe_oe_n         = strobe_oe_n_r;
  assign command_pullup_on        = cmd_pu_r;
  assign system_pullup_on         = sys_pu_r;
  assign data_out                 = dout_r;
  assign data_oe_n                = doe_n_r;
  assign carrier_modulated_output = mout_r;
  assign carrier_modulated_oe_n   = doe_n_r;

  // Checks
  a_idle_quiet: assert property (@(posedge core_clk) disable iff (clr)
    st_r == ST_IDLE |=> scan_strobe_oe_n == 8'h00 && data_oe_n)
    else $error("idle state left a strobe off or output driven");

  a_scan_onehot: assert property (@(posedge core_clk) disable iff (clr)
    st_r == ST_SCAN && $past(st_r) == ST_SCAN |=> $onehot(~scan_strobe_oe_n))
    else $error("scan does not drive exactly one strobe");

  a_debounce_len: assert property (@(posedge core_clk) disable iff (clr)
    st_r == ST_DEBOUNCE && st_nxt == ST_SCAN |-> unit_r == DEB_LAST && unit_done)
    else $error("debounce ended at wrong bit count");

  a_debounce_abort: assert property (@(posedge core_clk) disable iff (clr)
    st_r == ST_DEBOUNCE && !key_legal |=> st_r == ST_IDLE)
    else $error("broken contact did not abort debounce");

  a_frame_whole: assert property (@(posedge core_clk) disable iff (clr)
    st_r == ST_TX && !(unit_done && unit_r == TX_LAST) |=> st_r == ST_TX)
    else $error("frame cut short");

  a_frame_len: assert property (@(posedge core_clk) disable iff (clr)
    st_r == ST_TX && st_nxt == ST_GAP |-> unit_r == TX_LAST)
    else $error("frame length wrong");

  a_toggle_after: assert property (@(posedge core_clk) disable iff (clr)
    toggle_r != $past(toggle_r) |-> $past(sent_r) && st_r == ST_IDLE)
    else $error("toggle flipped without a sent frame");

  a_gap_release: assert property (@(posedge core_clk) disable iff (clr)
    st_r == ST_GAP && !key_any ##1 st_r == ST_IDLE |=> data_oe_n)
    else $error("release in gap did not quiet outputs");

  a_single_pullup: assert property (@(posedge core_clk) disable iff (clr)
    ssm_s && $stable(ssm_s) && st_r == ST_SCAN && !pass1 |=> !command_pullup_on && system_pullup_on)
    else $error("single mode pass one pull-ups wrong");

  a_wb_ack_pulse: assert property (@(posedge core_clk) disable iff (reset)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

/* common/rkt_pkg.sv */
// Constants, register map and state encoding for the remote keypad code transmitter
`default_nettype none

package rkt_pkg;

  // Core clock and oscillator timing
  localparam int CLK_PERIOD_NS  = 50;                              // 20 MHz core clock
  localparam int BIT_TIME_NS    = 1778000;                         // Typical bit-time
  localparam int OSC_PER_BIT    = 768;                             // Oscillator periods per bit
  localparam int OSC_PERIOD_NS  = BIT_TIME_NS / OSC_PER_BIT;       // Typical period, rounded down
  localparam int OSC_DIV_CYC    = OSC_PERIOD_NS / CLK_PERIOD_NS;   // Core cycles per osc period

  // Bit-time based sequence lengths
  localparam int DEB_BITS       = 18;                              // Uninterrupted contact time
  localparam int REP_BITS       = 4 * 16;                          // Frame repetition interval
  localparam int FRAME_BITS     = 14;                              // Start 2, toggle 1, sys 5, cmd 6
  localparam int SCAN_STEPS     = 8;                               // Strobe lines per pass
  localparam int SCAN_PASSES    = 2;                               // Scan passes before a frame
  localparam int SCAN_STEP_TICKS = OSC_PER_BIT / SCAN_STEPS;       // One strobe step
  localparam int SCAN_BITS      = SCAN_STEPS * SCAN_PASSES * SCAN_STEP_TICKS / OSC_PER_BIT;
  localparam int GAP_BITS       = REP_BITS - FRAME_BITS - SCAN_BITS;
  localparam int FAST_SCAN_DIV  = 3 * 2 ** 3;                      // Test speed-up of scanning
  localparam int FAST_READ_DIV  = 3 * 2 ** 7;                      // Test speed-up of read-out
  localparam int CAR_DIV        = 12;                              // Carrier = osc / 12
  localparam int CAR_HIGH       = CAR_DIV / 2;                     // 50 % duty

  // Osc-tick limits per unit of each state
  localparam logic [9:0] BIT_TICKS   = 10'(OSC_PER_BIT);
  localparam logic [9:0] STEP_TICKS  = 10'(SCAN_STEP_TICKS);
  localparam logic [9:0] STEP_FAST   = 10'(SCAN_STEP_TICKS / FAST_SCAN_DIV);
  localparam logic [9:0] HALF_TICKS  = 10'(OSC_PER_BIT / 2);
  localparam logic [9:0] HALF_FAST   = 10'(OSC_PER_BIT / 2 / FAST_READ_DIV);
  localparam logic [3:0] CAR_LAST    = 4'(CAR_DIV - 1);
  localparam logic [3:0] CAR_ON_CNT  = 4'(CAR_HIGH);

  // Last unit index of each state
  localparam logic [6:0] DEB_LAST    = 7'(DEB_BITS - 1);
  localparam logic [6:0] PASS0_LAST  = 7'(SCAN_STEPS - 1);
  localparam logic [6:0] SCAN_LAST   = 7'(SCAN_STEPS * SCAN_PASSES - 1);
  localparam logic [6:0] TX_LAST     = 7'(2 * FRAME_BITS - 1);
  localparam logic [6:0] GAP_LAST    = 7'(GAP_BITS - 1);

  // Frame contents
  localparam logic [1:0] START_BITS  = 2'h3;
  localparam logic [5:0] CMD_ALL_ONES = 6'h3f;

  // Wishbone register map
  localparam int         REG_AW      = 4;
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam int         CTRL_EN_BIT = 0;
  localparam logic       CTRL_EN_RST = 1'h1;
  localparam int         STAT_STATE_LSB = 0;
  localparam int         STAT_TOGGLE_BIT = 4;
  localparam int         STAT_SYS_LSB  = 8;
  localparam int         STAT_CMD_LSB  = 16;
  localparam int         STAT_SENT_BIT = 24;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_DEBOUNCE = 3'b001,
    ST_SCAN     = 3'b010,
    ST_TX       = 3'b011,
    ST_GAP      = 3'b100
  } rkt_state_t;

endpackage

`default_nettype wire

/* sim/rkt_keypad_model.sv */
// Key matrix model: one key, an optional wired system link, pull-ups
`default_nettype none

module rkt_keypad_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] strobe_oe_n,  // Low = strobe conducting
  input  wire logic       cmd_pu,       // Command pull-ups on
  input  wire logic       sys_pu,       // System pull-ups on
  input  wire logic [1:0] key_kind,     // 0 none, 1 command, 2 system
  input  wire logic [2:0] key_line,     // Sense index of the key
  input  wire logic [2:0] key_strobe,   // Strobe index of the key
  input  wire logic       wired_on,     // Wired system link present
  input  wire logic [4:0] wired_code,   // Wired link: line, strobe
  output logic      [7:0] cmd_sense,
  output logic      [3:0] sys_sense
);
  logic float_r = 1'b0;  // Unpulled lines wander every cycle
  wire  hit  = !strobe_oe_n[key_strobe];
  wire  whit = wired_on && !strobe_oe_n[wired_code[2:0]];

  // Floating level changes so an unknown never settles kindly
  always_ff @(posedge core_clk)
    float_r <= !float_r;

  // Key pulls its sense line low only while its strobe conducts
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      cmd_sense[i] = (key_kind == 2'd1 && key_line == i[2:0] && hit) ? 1'b0
                     : (cmd_pu ? 1'b1 : float_r);
    for (int i = 0; i < 4; i++)
      sys_sense[i] = ((key_kind == 2'd2 && key_line == i[2:0] && hit)
                     || (whit && wired_code[4:3] == i[1:0])) ? 1'b0
                     : (sys_pu ? 1'b1 : float_r);
  end
endmodule

`default_nettype wire

/* sim/rkt_top_tb.sv */
// Bench: key presses, register reads and frame capture
`default_nettype none

module rkt_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rkt_pkg::*;

  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, d;
  logic        ack, cpu, spu, dout, doe_n, mod, mod_oe_n;
  logic [7:0]  cmd_s, oe_n;
  logic [3:0]  sys_s;
  logic        ssel = 1'b0, tfs = 1'b0, tfr = 1'b0, osc = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic [2:0]  kline = 3'h0, kstb = 3'h0;
  logic        won = 1'b0;
  logic [4:0]  wcode = 5'h0;
  int          bad_count = 0, samples_checked = 0, cycles = 0, gate_bad = 0;
  logic        frame_q[$];  // Data level per cycle while driven

  rkt_top #(.OSC_DIV(2)) uut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .command_sense_inputs(cmd_s),
    .system_sense_inputs(sys_s), .single_system_select(ssel), .test_fast_scan(tfs),
    .test_fast_latch_read(tfr), .resonator_pin(osc), .scan_strobe_out(),
    .scan_strobe_oe_n(oe_n), .command_pullup_on(cpu), .system_pullup_on(spu),
    .data_out(dout), .data_oe_n(doe_n), .carrier_modulated_output(mod),
    .carrier_modulated_oe_n(mod_oe_n));

  rkt_keypad_model keys (.core_clk(core_clk), .strobe_oe_n(oe_n), .cmd_pu(cpu),
    .sys_pu(spu), .key_kind(kind), .key_line(kline), .key_strobe(kstb),
    .wired_on(won), .wired_code(wcode), .cmd_sense(cmd_s), .sys_sense(sys_s));

  initial
    forever #25 core_clk = ~core_clk;

  // Frame capture and carrier gating watch
  always @(posedge core_clk)
    if (doe_n === 1'b0)
    begin
      frame_q.push_back(dout);
      if (mod === 1'b1 && dout !== 1'b1)
        gate_bad++;
    end

  // Hang guard: three debounces need about 85k cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 110000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic cycle; waits for ack, read data taken at that edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    @(posedge core_clk);
    while (ack !== 1'b1)
      @(posedge core_clk);
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Poll the state field until it shows the wanted value
  task automatic wait_state(input logic [2:0] s);
    int n;
    n = 0;
    wb(1'b0, REG_STATUS, 32'h0);
    while (d[2:0] !== s && n < 40000)
    begin
      wb(1'b0, REG_STATUS, 32'h0);
      n++;
    end
    check("state", {29'h0, s}, {29'h0, d[2:0]});
  endtask

  // Half-bits last two cycles with fast read; one is low then high
  // Latched command may differ from the sent one when a system key alone is held
  task automatic check_frame(input logic tg, input logic [4:0] sy, input logic [5:0] cm,
                             input logic [5:0] cl);
    logic [13:0] b;
    b = {START_BITS, tg, sy, cm};
    check("frame length", 32'd56, 32'(frame_q.size()));
    if (frame_q.size() == 56)
      for (int i = 0; i < 28; i++)
        check("half bit", {31'h0, b[13 - i / 2] ^ (i % 2 == 0)}, {31'h0, frame_q[2 * i + 1]});
    wb(1'b0, REG_STATUS, 32'h0);
    check("latched codes", {21'h0, sy, cl}, {21'h0, d[12:8], d[21:16]});
    check("carrier gate", 32'h0, gate_bad);
  endtask

  // Press a key of the given kind, line and strobe
  task automatic press(input logic [1:0] k, input logic [2:0] ln, input logic [2:0] st);
    frame_q.delete();
    kind <= k;
    kline <= ln;
    kstb <= st;
  endtask

  initial
  begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    check("strobe enables", 32'h0, {24'h0, oe_n});
    check("data enable", 32'h1, {31'h0, doe_n});
    check("modulated enable", 32'h1, {31'h0, mod_oe_n});
    check("command pull-ups", 32'h1, {31'h0, cpu});
    wb(1'b0, REG_CTRL, 32'h0);
    check("ctrl enable", 32'h1, {31'h0, d[0]});
    wb(1'b0, 4'h8, 32'h0);
    check("unmapped read", 32'h0, d);
    $display("test idle done");
    // Break during debounce, then test initialisation
    press(2'd1, 3'd5, 3'd3);
    wait_state(3'd1);
    press(2'd0, 3'd5, 3'd3);
    wait_state(3'd0);
    check("toggle kept", 32'h0, {31'h0, d[4]});
    press(2'd1, 3'd5, 3'd3);
    wait_state(3'd1);
    tfs <= 1'b1;
    tfr <= 1'b1;
    osc <= 1'b1;
    repeat (10) @(posedge core_clk);
    wait_state(3'd0);
    osc <= 1'b0;
    $display("test abort done");
    // Command key, fast scan and read-out, release in the gap
    wait_state(3'd4);
    check_frame(1'b0, 5'h00, 6'h2b, 6'h2b);
    press(2'd0, 3'd0, 3'd0);
    wait_state(3'd0);
    check("toggle", 32'h1, {31'h0, d[4]});
    $display("test command done");
    // System key alone sends the all-ones command
    press(2'd2, 3'd2, 3'd6);
    wait_state(3'd4);
    check_frame(1'b1, 5'h16, CMD_ALL_ONES, 6'h2b);
    press(2'd0, 3'd0, 3'd0);
    wait_state(3'd0);
    check("toggle", 32'h0, {31'h0, d[4]});
    $display("test system done");
    // Single mode with a wired system link
    ssel <= 1'b1;
    repeat (5) @(posedge core_clk);
    won <= 1'b1;
    wcode <= 5'h19;
    repeat (5) @(posedge core_clk);
    check("system pull-ups", 32'h0, {31'h0, spu});
    press(2'd1, 3'd4, 3'd0);
    wait_state(3'd4);
    check_frame(1'b0, 5'h19, 6'h20, 6'h20);
    $display("test single done");
    give_verdict();
  end
endmodule

`default_nettype wire
